// >>> include/stamp_cfg_regs.svh
/*
  Constants of the time stamping link: record numbers, field positions,
  status codes and sizes.
  Assumes inclusion by bare name from the include folder.
*/
`ifndef STAMP_CFG_REGS_SVH
`define STAMP_CFG_REGS_SVH
`define CFG_RECORD_NUM      8'hF0
`define MSG_RECORD_FIRST    8'h64
`define MSG_RECORD_LAST     8'h72
`define MSG_RECORD_COUNT    4'hF
`define CFG_HEADER_BYTES    8'h04
`define CFG_SLOTS_BYTE      8'h05
`define CFG_FIRST_SLOT_BYTE 8'h06
`define SLOTS_MAX           4'hC
`define SLOT_NUM_MIN        8'h04
`define SLOT_NUM_MAX        8'h0F
`define INPUTS_MAX          6'h20
`define FMT_POS             6
`define STATUS_INCOMING     8'h80
`define STATUS_OUTGOING     8'h00
`define MSG_BYTES           8'h0C
`define MSGS_PER_RECORD     5'h14
`define READ_ERROR_CODE     16'h80B0
`define RESTART_BIT         5
`endif

// >>> include/stamp_pkg.sv
/*
  Types shared by both ends of the time stamping link.
  Assumes stamp_cfg_regs.svh holds the numeric constants.
*/
package stamp_pkg;
  typedef enum logic [1:0] {
    CODE_OFF0    = 2'h0,
    CODE_FALLING = 2'h1,
    CODE_OFF1    = 2'h2,
    CODE_RISING  = 2'h3
  } input_edge_select_t;
  typedef enum logic [1:0] {
    FMT_PLAIN    = 2'h0,
    FMT_STATUS   = 2'h1,
    FMT_RES2     = 2'h2,
    FMT_RES3     = 2'h3
  } sample_format_field_t;
  typedef struct packed {
    logic [7:0] slot;
    logic [7:0] channel;
    logic [7:0] status;
  } message_t;
endpackage

// >>> include/stamp_link_if.sv
/*
  Link between the bus master end and the stamping slave end.
  Assumes both ends share one clock and reset.
*/
`timescale 1ns/1ps
interface stamp_link_if (
  input wire logic clk,
  input wire logic rst_n
);
  // Record write service: one byte per cycle, wrLast ends the record.
  logic        wrValid;
  logic [7:0]  wrRecord;
  logic [7:0]  wrData;
  logic        wrLast;
  // Process interrupt, held until a diagnosis request.
  logic        procInt;
  logic        diagReq;
  logic        diagValid;
  logic [7:0]  diagAddr;
  logic [7:0]  diagRecord;
  logic [7:0]  diagCount;
  logic [7:0]  diagStatus;
  // Record read service.
  logic        rdReq;
  logic [7:0]  rdRecord;
  logic        rdValid;
  logic [7:0]  rdData;
  logic        rdLast;
  logic        rdError;
  logic [15:0] rdErrCode;
  modport device (
    input  wrValid, wrRecord, wrData, wrLast, diagReq, rdReq, rdRecord,
    output procInt, diagValid, diagAddr, diagRecord, diagCount,
    output diagStatus, rdValid, rdData, rdLast, rdError, rdErrCode
  );
  modport master (
    output wrValid, wrRecord, wrData, wrLast, diagReq, rdReq, rdRecord,
    input  procInt, diagValid, diagAddr, diagRecord, diagCount,
    input  diagStatus, rdValid, rdData, rdLast, rdError, rdErrCode
  );
endinterface

// >>> verilog/stamp_slave.sv
/*
  Slave end: takes the stamping configuration record, watches 32 inputs
  of each configured slot, stores messages in fifteen records, raises the
  process interrupt, answers diagnosis and record reads.
  Assumes the input pins are asynchronous and the master keeps its side.
*/
// Operation
// - Interrupt master when new messages are stored
// - Master asks diagnosis; slave answers with frame
// - Frame reports address, record number, count
// - Master reads reported record 100 to 114
// - Master clears new flag before next record
// - Master configures by writing record 240
// - First four record bytes are header
// - Byte 5 slot count; zero disables
// - Slot number byte valid 4 to 15
// - Slot entries follow back to back
// - Format field and input count byte
// - Four two-bit codes per control byte
// - Decode off, rising incoming, falling incoming
// - Opposite edge stamped as outgoing
// - Incoming edge stores status 80h message
// - Twelve byte messages, twenty per record
// - Bad record or unconfigured read errors
// - Status bit 5 flags re-established stamping
`timescale 1ns/1ps
`include "stamp_cfg_regs.svh"
module stamp_slave (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  stamp_link_if.device               link,
  input  wire logic [7:0]            diagAddress,
  input  wire logic [15:0][31:0]     inputPins,
  output      logic                  stampActive
);
  import stamp_pkg::*;

  logic [15:0][63:0] edgeCfg, next_edgeCfg;
  logic [15:0]       slotOn, next_slotOn;
  logic [3:0]        slotsLeft, next_slotsLeft;
  logic [7:0]        wrIdx, next_wrIdx, entryIdx, next_entryIdx;
  logic [3:0]        curSlot, next_curSlot;
  logic [5:0]        inCount, next_inCount;
  logic              configured, next_configured;
  logic              restartFlag, next_restartFlag;
  logic              stampOn, next_stampOn;
  logic [15:0][31:0] sync1, sync2, prev;
  logic [7:0]        mem [0:14][0:239];
  logic [4:0]        msgCnt [0:14];
  logic [3:0]        fillRec, next_fillRec;
  logic [3:0]        reportRec, next_reportRec;
  logic              pending, next_pending;
  logic              hit;
  logic [3:0]        hitSlot;
  logic [4:0]        hitCh;
  logic              hitRise;
  logic [7:0]        rdPtr, next_rdPtr;
  logic              reading, next_reading;
  logic [3:0]        record_read_block;

  ////////////////////////////////////////////////////////////////////////
  // Input pins pass two flip-flops; prev holds the last synced value.
  always_ff @(posedge clk) begin
    sync1 <= inputPins;
    sync2 <= sync1;
    prev  <= rst_n ? sync2 : '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration record parser, one byte per write beat.
  always_comb begin
    next_edgeCfg     = edgeCfg;
    next_slotOn      = slotOn;
    next_slotsLeft   = slotsLeft;
    next_wrIdx       = wrIdx;
    next_entryIdx    = entryIdx;
    next_curSlot     = curSlot;
    next_inCount     = inCount;
    next_configured  = configured;
    next_stampOn     = stampOn;
    if (link.wrValid && link.wrRecord == `CFG_RECORD_NUM) begin
      next_wrIdx = link.wrLast ? 8'h00 : wrIdx + 8'h01;
      if (wrIdx == 8'h00) begin
        next_edgeCfg = '0;
        next_slotOn  = '0;
      end
      if (wrIdx < `CFG_HEADER_BYTES) begin
        next_entryIdx = 8'h00;
      end else if (wrIdx == `CFG_SLOTS_BYTE) begin
        next_slotsLeft = (link.wrData[3:0] > `SLOTS_MAX) ? `SLOTS_MAX
                         : link.wrData[3:0];
        next_stampOn   = link.wrData[3:0] != 4'h0;
      end else if (wrIdx >= `CFG_FIRST_SLOT_BYTE && slotsLeft != 4'h0) begin
        next_entryIdx = entryIdx + 8'h01;
        if (entryIdx == 8'h00) begin
          next_curSlot = link.wrData[3:0];
          next_slotOn[link.wrData[3:0]] = link.wrData >= `SLOT_NUM_MIN &&
                                         link.wrData <= `SLOT_NUM_MAX;
        end else if (entryIdx == 8'h01) begin
          next_inCount = link.wrData[5:0];
          if (link.wrData[7:`FMT_POS] > FMT_STATUS)
            next_slotOn[curSlot] = 1'b0;
        end else begin
          next_edgeCfg[curSlot][(entryIdx - 8'h02) * 8 +: 8]
            = link.wrData;
          if ({2'h0, inCount} <= {entryIdx[5:0] - 6'h1, 2'h0} ||
              entryIdx == 8'h09) begin
            next_entryIdx  = 8'h00;
            next_slotsLeft = slotsLeft - 4'h1;
          end
        end
      end
      if (link.wrLast)
        next_configured = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      edgeCfg    <= '0;
      slotOn     <= '0;
      slotsLeft  <= 4'h0;
      wrIdx      <= 8'h00;
      entryIdx   <= 8'h00;
      curSlot    <= 4'h0;
      inCount    <= 6'h00;
      configured <= 1'b0;
      stampOn    <= 1'b0;
    end else begin
      edgeCfg    <= next_edgeCfg;
      slotOn     <= next_slotOn;
      slotsLeft  <= next_slotsLeft;
      wrIdx      <= next_wrIdx;
      entryIdx   <= next_entryIdx;
      curSlot    <= next_curSlot;
      inCount    <= next_inCount;
      configured <= next_configured;
      stampOn    <= next_stampOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge search: lowest slot and channel with an enabled change wins;
  // others changing in the same cycle are dropped, a known limitation.
  always_comb begin
    logic [1:0] code;
    code    = 2'h0;
    hit     = 1'b0;
    hitSlot = 4'h0;
    hitCh   = 5'h00;
    hitRise = 1'b0;
    for (int s = 15; s >= 0; s--) begin
      for (int c = 31; c >= 0; c--) begin
        code = edgeCfg[s][c*2 +: 2];
        if (stampOn && slotOn[s] && code[0] &&
            sync2[s][c] != prev[s][c]) begin
          hit     = 1'b1;
          hitSlot = 4'(s);
          hitCh   = 5'(c);
          hitRise = sync2[s][c];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Message store, record rotation and interrupt state.
  always_comb begin
    next_fillRec     = fillRec;
    next_reportRec   = reportRec;
    next_pending     = pending;
    next_restartFlag = restartFlag;
    if (link.diagReq && link.diagValid == 1'b0 && pending)
      next_restartFlag = 1'b0;
    // A new configuration wins over a clear in the same cycle.
    if (link.wrValid && link.wrLast &&
        link.wrRecord == `CFG_RECORD_NUM)
      next_restartFlag = 1'b1;
    if (link.diagReq && pending)
      next_pending = 1'b0;
    // Report a record when idle, or when the fill record is full.
    if (hit && (!pending ||
        msgCnt[fillRec] == `MSGS_PER_RECORD - 5'h01)) begin
      next_reportRec = fillRec;
      next_pending   = 1'b1;
      next_fillRec   = (fillRec == `MSG_RECORD_COUNT - 4'h1) ? 4'h0
                       : fillRec + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fillRec     <= 4'h0;
      reportRec   <= 4'h0;
      pending     <= 1'b0;
      restartFlag <= 1'b1;
      for (int r = 0; r < 15; r++)
        msgCnt[r] <= 5'h00;
    end else begin
      fillRec     <= next_fillRec;
      reportRec   <= next_reportRec;
      pending     <= next_pending;
      restartFlag <= next_restartFlag;
      // Count clears after the last byte is read; a new message wins.
      if (reading && !next_reading)
        msgCnt[record_read_block] <= 5'h00;
      if (hit) begin
        msgCnt[fillRec] <= msgCnt[fillRec] + 5'h01;
        mem[fillRec][msgCnt[fillRec]*12 + 0] <= {4'h0, hitSlot};
        mem[fillRec][msgCnt[fillRec]*12 + 1] <= {3'h0, hitCh};
        mem[fillRec][msgCnt[fillRec]*12 + 2] <=
          (hitRise == edgeCfg[hitSlot][hitCh*2+1]) ? `STATUS_INCOMING
          : `STATUS_OUTGOING;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Diagnosis answer and record read, one byte per cycle.
  assign record_read_block = 4'(link.rdRecord - `MSG_RECORD_FIRST);
  always_comb begin
    next_reading = reading;
    next_rdPtr   = rdPtr;
    if (link.rdReq && !reading && configured &&
        link.rdRecord >= `MSG_RECORD_FIRST &&
        link.rdRecord <= `MSG_RECORD_LAST) begin
      next_reading = 1'b1;
      next_rdPtr   = 8'h00;
    end else if (reading) begin
      next_rdPtr = rdPtr + 8'h01;
      if (rdPtr + 8'h01 >= 8'(msgCnt[record_read_block]) * `MSG_BYTES)
        next_reading = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reading         <= 1'b0;
      rdPtr           <= 8'h00;
      link.procInt    <= 1'b0;
      link.diagValid  <= 1'b0;
      link.diagAddr   <= 8'h00;
      link.diagRecord <= 8'h00;
      link.diagCount  <= 8'h00;
      link.diagStatus <= 8'h00;
      link.rdValid    <= 1'b0;
      link.rdData     <= 8'h00;
      link.rdLast     <= 1'b0;
      link.rdError    <= 1'b0;
      link.rdErrCode  <= 16'h0000;
      stampActive     <= 1'b0;
    end else begin
      reading         <= next_reading;
      rdPtr           <= next_rdPtr;
      stampActive     <= stampOn;
      link.procInt    <= next_pending;
      link.diagValid  <= link.diagReq;
      link.diagAddr   <= diagAddress;
      link.diagRecord <= `MSG_RECORD_FIRST + {4'h0, reportRec};
      link.diagCount  <= {3'h0, msgCnt[reportRec]};
      link.diagStatus <= {2'h0, restartFlag, 5'h00};
      link.rdError    <= link.rdReq && !reading && (!configured ||
                         link.rdRecord < `MSG_RECORD_FIRST ||
                         link.rdRecord > `MSG_RECORD_LAST);
      link.rdErrCode  <= `READ_ERROR_CODE;
      link.rdValid    <= reading;
      link.rdData     <= reading ? mem[record_read_block][rdPtr] : 8'h00;
      link.rdLast     <= reading && !next_reading;
    end
  end
endmodule

// >>> verilog/stamp_master.sv
/*
  Master end: writes the configuration record from a user byte port,
  answers the process interrupt with a diagnosis request, reads the
  reported record and hands the bytes out, then clears its new flag.
  Assumes the slave end keeps its side of the link.
*/
`timescale 1ns/1ps
`include "stamp_cfg_regs.svh"
module stamp_master (
  input  wire logic       clk,
  input  wire logic       rst_n,
  stamp_link_if.master    link,
  input  wire logic       cfgValid,
  input  wire logic [7:0] cfgData,
  input  wire logic       cfgLast,
  output      logic       newFlag,
  output      logic [7:0] reportedRecord,
  output      logic [7:0] reportedCount,
  output      logic       restartSeen,
  output      logic       userValid,
  output      logic [7:0] userData
);
  import stamp_pkg::*;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_DIAG = 2'b01, M_READ = 2'b11, M_WAIT = 2'b10
  } mstate_t;
  mstate_t    st, next_st;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt, diagnosis, record read, flag clear sequence.
  always_comb begin
    next_st = st;
    unique case (st)
      M_IDLE: if (link.procInt) next_st = M_DIAG;
      M_DIAG: if (link.diagValid) next_st = M_READ;
      M_READ: next_st = M_WAIT;
      M_WAIT: if (link.rdLast || link.rdError) next_st = M_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st             <= M_IDLE;
      newFlag        <= 1'b0;
      reportedRecord <= 8'h00;
      reportedCount  <= 8'h00;
      restartSeen    <= 1'b0;
      userValid      <= 1'b0;
      userData       <= 8'h00;
      link.wrValid   <= 1'b0;
      link.wrRecord  <= 8'h00;
      link.wrData    <= 8'h00;
      link.wrLast    <= 1'b0;
      link.diagReq   <= 1'b0;
      link.rdReq     <= 1'b0;
      link.rdRecord  <= 8'h00;
    end else begin
      st            <= next_st;
      link.wrValid  <= cfgValid;
      link.wrRecord <= `CFG_RECORD_NUM;
      link.wrData   <= cfgData;
      link.wrLast   <= cfgValid && cfgLast;
      link.diagReq  <= st == M_IDLE && link.procInt;
      link.rdReq    <= st == M_DIAG && link.diagValid;
      if (st == M_DIAG && link.diagValid) begin
        newFlag        <= 1'b1;
        reportedRecord <= link.diagRecord;
        reportedCount  <= link.diagCount;
        restartSeen    <= link.diagStatus[`RESTART_BIT];
        link.rdRecord  <= link.diagRecord;
      end else if (st == M_WAIT && (link.rdLast || link.rdError)) begin
        newFlag <= 1'b0;
      end
      userValid <= link.rdValid;
      userData  <= link.rdData;
    end
  end
endmodule

// >>> test/stamp_link_props.sv
/*
  Checker of the link between the master and slave ends.
  Assumes the testbench hands it the link signals by name.
*/
`timescale 1ns/1ps
`include "stamp_cfg_regs.svh"
module stamp_link_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wrValid,
  input wire logic [7:0]  wrRecord,
  input wire logic        procInt,
  input wire logic        diagReq,
  input wire logic        diagValid,
  input wire logic [7:0]  diagRecord,
  input wire logic [7:0]  diagCount,
  input wire logic        rdReq,
  input wire logic [7:0]  rdRecord,
  input wire logic        rdValid,
  input wire logic [7:0]  rdData,
  input wire logic        rdLast,
  input wire logic        rdError,
  input wire logic [15:0] rdErrCode
);
  logic [7:0] byteIdx;
  logic [7:0] next_byteIdx;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  // Position of the read byte inside its twelve byte message.
  always_comb begin
    next_byteIdx = byteIdx;
    if (rdLast || (rdValid && byteIdx == 8'h0B)) begin
      next_byteIdx = 8'h00;
    end else if (rdValid) begin
      next_byteIdx = byteIdx + 8'h01;
    end
  end
  // Registers the byte position.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byteIdx <= 8'h00;
    end else begin
      byteIdx <= next_byteIdx;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  property p_int_hold;
    procInt && !diagReq |=> procInt;
  endproperty
  a_int_hold: assert property (p_int_hold)
    else $error("interrupt dropped before diagnosis request");
  property p_diag_ans;
    diagReq |=> diagValid ##1 !diagValid;
  endproperty
  a_diag_ans: assert property (p_diag_ans)
    else $error("diagnosis answer missing or not one cycle");
  property p_diag_rec;
    diagValid |-> diagRecord >= `MSG_RECORD_FIRST
      && diagRecord <= `MSG_RECORD_LAST;
  endproperty
  a_diag_rec: assert property (p_diag_rec)
    else $error("reported record out of range");
  property p_diag_cnt;
    diagValid |-> diagCount >= 8'h01 && diagCount <= 8'h14;
  endproperty
  a_diag_cnt: assert property (p_diag_cnt)
    else $error("reported message count out of range");
  property p_rd_err;
    rdReq && (rdRecord < `MSG_RECORD_FIRST || rdRecord > `MSG_RECORD_LAST)
      |=> rdError && rdErrCode == `READ_ERROR_CODE;
  endproperty
  a_rd_err: assert property (p_rd_err)
    else $error("bad record read not refused");
  property p_rd_ans;
    rdReq ##1 !rdError |=> rdValid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("record read gave no data");
  property p_wr_rec;
    wrValid |-> wrRecord == `CFG_RECORD_NUM;
  endproperty
  a_wr_rec: assert property (p_wr_rec)
    else $error("configuration written to wrong record");
  property p_slot;
    rdValid && byteIdx == 8'h00 |-> rdData >= `SLOT_NUM_MIN
      && rdData <= `SLOT_NUM_MAX;
  endproperty
  a_slot: assert property (p_slot)
    else $error("message slot byte out of range");
  property p_status;
    rdValid && byteIdx == 8'h02 |-> rdData == `STATUS_INCOMING
      || rdData == `STATUS_OUTGOING;
  endproperty
  a_status: assert property (p_status)
    else $error("message status code unknown");
endmodule

// >>> test/input_edge_time_stamp_config_tb_top.sv
/*
  Testbench joining master and slave ends over one link.
  Assumes the master reads each reported record and hands out its bytes.
*/
`timescale 1ns/1ps
module input_edge_time_stamp_config_tb_top;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              cfgValid = 1'b0;
  logic [7:0]        cfgData = 8'h00;
  logic              cfgLast = 1'b0;
  logic [15:0][31:0] pins = '0;
  logic              newFlag, restartSeen, userValid, stampActive;
  logic [7:0]        reportedRecord, reportedCount, userData;
  logic [7:0]        cfgBuf [0:25];
  logic [7:0]        msg [0:11];
  logic [7:0]        expRec = 8'h64;
  int                miscompares = 0;
  int                checks_done = 0;
  // Clock of 100 MHz.
  always #5 clk = ~clk;
  stamp_link_if link (.clk(clk), .rst_n(rst_n));
  stamp_slave stamp_slave_inst (.clk(clk), .rst_n(rst_n), .link(link),
    .diagAddress(8'h21), .inputPins(pins), .stampActive(stampActive));
  stamp_master stamp_master_inst (.clk(clk), .rst_n(rst_n), .link(link),
    .cfgValid(cfgValid), .cfgData(cfgData), .cfgLast(cfgLast),
    .newFlag(newFlag), .reportedRecord(reportedRecord),
    .reportedCount(reportedCount), .restartSeen(restartSeen),
    .userValid(userValid), .userData(userData));
  stamp_link_props stamp_link_props_inst (.clk(clk), .rst_n(rst_n),
    .wrValid(link.wrValid), .wrRecord(link.wrRecord),
    .procInt(link.procInt), .diagReq(link.diagReq),
    .diagValid(link.diagValid), .diagRecord(link.diagRecord),
    .diagCount(link.diagCount), .rdReq(link.rdReq),
    .rdRecord(link.rdRecord), .rdValid(link.rdValid),
    .rdData(link.rdData), .rdLast(link.rdLast),
    .rdError(link.rdError), .rdErrCode(link.rdErrCode));
  //////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Sends the first n bytes of the record buffer, one a cycle.
  task automatic send_cfg(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      cfgValid <= 1'b1;
      cfgData <= cfgBuf[i];
      cfgLast <= (i == n - 1);
    end
    @(posedge clk);
    cfgValid <= 1'b0;
    cfgLast <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic set_pin(input int s, input int c, input logic v);
    @(posedge clk);
    pins[s][c] <= v;
  endtask
  // Collects one handed out message and judges it and the report.
  task automatic check_msg(input logic [7:0] s, c, st);
    int i;
    int t;
    i = 0;
    t = 0;
    while (i < 12 && t < 2000) begin
      @(negedge clk);
      t++;
      if (link.diagValid === 1'b1)
        chk(link.diagAddr === 8'h21, "diagnostic address wrong");
      if (userValid === 1'b1) begin
        msg[i] = userData;
        i++;
      end
    end
    chk(i == 12, "message bytes missing");
    chk(msg[0] === s && msg[1] === c, "message source wrong");
    chk(msg[2] === st, "message status wrong");
    chk(reportedRecord === expRec, "reported record wrong");
    chk(reportedCount === 8'h01, "reported count wrong");
    repeat (4) @(negedge clk);
    chk(newFlag === 1'b0, "new flag not cleared");
    expRec = (expRec == 8'h72) ? 8'h64 : expRec + 8'h01;
  endtask
  // Toggles an input that must not be stamped and watches the interrupt.
  task automatic no_msg(input int s, input int c, input logic v);
    set_pin(s, c, v);
    repeat (60) begin
      @(negedge clk);
      chk(link.procInt === 1'b0, "unexpected interrupt");
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic test_config;
    cfgBuf = '{8'h00, 8'h00, 8'hF0, 8'h16, 8'h02, 8'h02, 8'h04, 8'h20,
               8'h87, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
               8'h05, 8'h60, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
               8'h00, 8'h00};
    send_cfg(26);
    chk(stampActive === 1'b1, "stamping not active");
  endtask
  task automatic test_rising;
    set_pin(4, 0, 1'b1);
    check_msg(8'h04, 8'h00, 8'h80);
    chk(restartSeen === 1'b1, "restart bit missing");
    set_pin(4, 0, 1'b0);
    check_msg(8'h04, 8'h00, 8'h00);
    chk(restartSeen === 1'b0, "restart bit stuck");
  endtask
  task automatic test_falling;
    set_pin(4, 1, 1'b1);
    check_msg(8'h04, 8'h01, 8'h00);
    set_pin(4, 1, 1'b0);
    check_msg(8'h04, 8'h01, 8'h80);
  endtask
  task automatic test_off;
    no_msg(4, 2, 1'b1);
    no_msg(4, 3, 1'b1);
  endtask
  task automatic test_second_slot;
    set_pin(5, 0, 1'b1);
    check_msg(8'h05, 8'h00, 8'h80);
  endtask
  task automatic test_reserved;
    cfgBuf[17] = 8'hA0;
    send_cfg(26);
    no_msg(5, 0, 1'b0);
  endtask
  task automatic test_disable;
    cfgBuf[5] = 8'h00;
    send_cfg(6);
    chk(stampActive === 1'b0, "stamping still active");
    no_msg(4, 0, 1'b1);
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_config();
    test_rising();
    test_falling();
    test_off();
    test_second_slot();
    test_reserved();
    test_disable();
    results();
  end
  // Cuts a hang short.
  initial begin
    #500us;
    miscompares++;
    results();
  end
endmodule
